/* File: logic/slow_ctrl_bank.sv */
`timescale 1ns/1ps
module slow_ctrl_bank (
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    input  wire slow_ctrl_pkg::access_type            req,
    output logic                                      rd_valid,
    output logic      [slow_ctrl_pkg::DATA_W-1:0]     rd_data,
    output slow_ctrl_pkg::params_type                 params,
    output logic      [slow_ctrl_pkg::PULSE_W-1:0]    pulse,
    input  wire logic [slow_ctrl_pkg::DATA_W-1:0]     err_check,
    input  wire logic [slow_ctrl_pkg::INPUT_W-1:0]    input_err,
    input  wire logic                                 spy_we,
    input  wire logic [slow_ctrl_pkg::RAM_AW-1:0]     spy_addr,
    input  wire logic [slow_ctrl_pkg::DATA_W-1:0]     spy_data,
    input  wire logic                                 fifo_push,
    input  wire logic [slow_ctrl_pkg::DATA_W-1:0]     fifo_data,
    input  wire logic                                 fifo_pop,
    output logic                                      fifo_out_valid,
    output logic      [slow_ctrl_pkg::DATA_W-1:0]     fifo_out_data,
    output logic                                      fifo_full,
    output logic                                      fifo_empty
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta;
    logic rst_n_sync;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_n_sync <= rst_meta;
        end
    end

    function automatic logic in_window(input logic [7:0] a,
                                       input logic [7:0] base,
                                       input int         depth);
        in_window = (a >= base) && ({24'h0, a} < {24'h0, base} + depth);
    endfunction

    logic wr_ctrl;
    logic wr_ram;
    logic rd_fifo;
    assign wr_ctrl = req.wr;
    assign wr_ram  = req.wr && in_window(req.addr, slow_ctrl_pkg::RAM_BASE,
                                         slow_ctrl_pkg::RAM_DEPTH);
    assign rd_fifo = in_window(req.addr, slow_ctrl_pkg::FIFO_BASE,
                               slow_ctrl_pkg::FIFO_DEPTH);

    ////////////////////////////////////////////////////////////////////////
    // Control registers, only bus writes touch them; undefined bits dropped

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            params <= slow_ctrl_pkg::PARAMS_RESET;
        end else if (wr_ctrl) begin
            if (req.addr == slow_ctrl_pkg::OFS_TOB_READOUT_EN) begin
                params.tob_readout_en <= req.wdata[0];
            end else if (req.addr == slow_ctrl_pkg::OFS_INPUT_MASK) begin
                params.input_mask <= req.wdata;
            end else if (req.addr == slow_ctrl_pkg::OFS_RO_MODE) begin
                params.ro_mode <= req.wdata[slow_ctrl_pkg::MODE_W-1:0];
            end else if (req.addr == slow_ctrl_pkg::OFS_RO_MASK) begin
                params.ro_mask <= req.wdata;
            end else if (req.addr == slow_ctrl_pkg::OFS_DEAD_TIME) begin
                params.dead_time <= req.wdata[slow_ctrl_pkg::DEAD_W-1:0];
            end else if (req.addr == slow_ctrl_pkg::OFS_INPUT_DELAY) begin
                params.input_delay <= req.wdata[slow_ctrl_pkg::DELAY_W-1:0];
            end else if (req.addr == slow_ctrl_pkg::OFS_FRAME_LEN) begin
                params.frame_len <= req.wdata[slow_ctrl_pkg::FRAME_W-1:0];
            end else if (req.addr == slow_ctrl_pkg::OFS_RO_OFS_INPUT) begin
                params.ofs_input <= req.wdata[slow_ctrl_pkg::OFS_W-1:0];
            end else if (req.addr == slow_ctrl_pkg::OFS_RO_OFS_INTER) begin
                params.ofs_inter <= req.wdata[slow_ctrl_pkg::OFS_W-1:0];
            end else if (req.addr == slow_ctrl_pkg::OFS_RO_OFS_FINAL) begin
                params.ofs_final <= req.wdata[slow_ctrl_pkg::OFS_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse register

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pulse <= '0;
        end else if (req.wr && req.addr == slow_ctrl_pkg::OFS_PULSE) begin
            pulse <= req.wdata[slow_ctrl_pkg::PULSE_W-1:0];
        end else begin
            pulse <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status registers, written by module logic only

    logic                                 err_latch;
    logic [slow_ctrl_pkg::INPUT_W-1:0]    err_mask;
    logic [slow_ctrl_pkg::DATA_W-1:0]     err_count;
    logic                                 clear_err;
    assign clear_err = pulse[slow_ctrl_pkg::PULSE_CLEAR_ERR];

    // A new error in the clearing cycle survives the clear
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            err_latch <= 1'b0;
            err_mask  <= '0;
        end else begin
            err_latch <= (err_latch && !clear_err) || (|input_err);
            err_mask  <= (clear_err ? '0 : err_mask) | input_err;
        end
    end

    // Saturates rather than wrapping, so a flood never reads as quiet
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            err_count <= slow_ctrl_pkg::DATA_RESET;
        end else if (|input_err) begin
            if (clear_err) begin
                err_count <= 32'h0000_0001;
            end else if (err_count != 32'hffff_ffff) begin
                err_count <= err_count + 32'h0000_0001;
            end
        end else if (clear_err) begin
            err_count <= slow_ctrl_pkg::DATA_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readout FIFO with non-destructive peek

    logic [slow_ctrl_pkg::DATA_W-1:0]  fifo_mem [slow_ctrl_pkg::FIFO_DEPTH];
    logic [slow_ctrl_pkg::FIFO_AW-1:0] wr_ptr;
    logic [slow_ctrl_pkg::FIFO_AW-1:0] rd_ptr;
    logic [slow_ctrl_pkg::CNT_W-1:0]   fifo_count;
    logic [slow_ctrl_pkg::CNT_W-1:0]   next_fifo_count;
    logic                              do_push;
    logic                              do_pop;
    logic                              flush;

    assign flush   = pulse[slow_ctrl_pkg::PULSE_READOUT_RESET];
    assign do_push = fifo_push && !fifo_full;
    assign do_pop  = fifo_pop && !fifo_empty;

    always_comb begin
        next_fifo_count = fifo_count;
        if (flush) begin
            next_fifo_count = '0;
        end else if (do_push && !do_pop) begin
            next_fifo_count = fifo_count + 5'h01;
        end else if (do_pop && !do_push) begin
            next_fifo_count = fifo_count - 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            fifo_mem[wr_ptr] <= fifo_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            wr_ptr         <= '0;
            rd_ptr         <= '0;
            fifo_count     <= '0;
            fifo_full      <= 1'b0;
            fifo_empty     <= 1'b1;
            fifo_out_valid <= 1'b0;
            fifo_out_data  <= slow_ctrl_pkg::DATA_RESET;
        end else begin
            fifo_count     <= next_fifo_count;
            fifo_full      <= next_fifo_count == 5'h10;
            fifo_empty     <= next_fifo_count == 5'h00;
            fifo_out_valid <= do_pop && !flush;
            if (do_pop) begin
                fifo_out_data <= fifo_mem[rd_ptr];
            end
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
            end else begin
                wr_ptr <= do_push ? wr_ptr + 4'h1 : wr_ptr;
                rd_ptr <= do_pop ? rd_ptr + 4'h1 : rd_ptr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Spy and readout RAM

    logic [slow_ctrl_pkg::DATA_W-1:0] ram_rdata;

    readout_ram u_ram (
        .clk     (clk),
        .a_we    (wr_ram),
        .a_addr  (req.addr[slow_ctrl_pkg::RAM_AW-1:0]),
        .a_wdata (req.wdata),
        .a_rdata (ram_rdata),
        .b_we    (spy_we),
        .b_addr  (spy_addr),
        .b_wdata (spy_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path, sampled in one edge so every word is one snapshot

    logic [slow_ctrl_pkg::DATA_W-1:0]  next_rd_data;
    logic [slow_ctrl_pkg::FIFO_AW-1:0] peek_idx;
    assign peek_idx = req.addr[slow_ctrl_pkg::FIFO_AW-1:0];

    always_comb begin
        next_rd_data = '0;
        if (req.addr == slow_ctrl_pkg::OFS_TOB_READOUT_EN) begin
            next_rd_data = 32'(params.tob_readout_en);
        end else if (req.addr == slow_ctrl_pkg::OFS_INPUT_MASK) begin
            next_rd_data = params.input_mask;
        end else if (req.addr == slow_ctrl_pkg::OFS_RO_MODE) begin
            next_rd_data = 32'(params.ro_mode);
        end else if (req.addr == slow_ctrl_pkg::OFS_RO_MASK) begin
            next_rd_data = params.ro_mask;
        end else if (req.addr == slow_ctrl_pkg::OFS_DEAD_TIME) begin
            next_rd_data = 32'(params.dead_time);
        end else if (req.addr == slow_ctrl_pkg::OFS_INPUT_DELAY) begin
            next_rd_data = 32'(params.input_delay);
        end else if (req.addr == slow_ctrl_pkg::OFS_FRAME_LEN) begin
            next_rd_data = 32'(params.frame_len);
        end else if (req.addr == slow_ctrl_pkg::OFS_RO_OFS_INPUT) begin
            next_rd_data = 32'(params.ofs_input);
        end else if (req.addr == slow_ctrl_pkg::OFS_RO_OFS_INTER) begin
            next_rd_data = 32'(params.ofs_inter);
        end else if (req.addr == slow_ctrl_pkg::OFS_RO_OFS_FINAL) begin
            next_rd_data = 32'(params.ofs_final);
        end else if (req.addr == slow_ctrl_pkg::OFS_ERR_CHECK) begin
            next_rd_data = err_check;
        end else if (req.addr == slow_ctrl_pkg::OFS_ERR_COUNT) begin
            next_rd_data = err_count;
        end else if (req.addr == slow_ctrl_pkg::OFS_ERR_LATCH) begin
            next_rd_data = 32'(err_latch);
        end else if (req.addr == slow_ctrl_pkg::OFS_ERR_MASK) begin
            next_rd_data = err_mask;
        end else if (req.addr == slow_ctrl_pkg::OFS_RO_STATUS) begin
            next_rd_data = {19'h0, fifo_count, params.frame_len};
        end else if (in_window(req.addr, slow_ctrl_pkg::RAM_BASE,
                               slow_ctrl_pkg::RAM_DEPTH)) begin
            next_rd_data = ram_rdata;
        end else if (rd_fifo && ({1'b0, peek_idx} < fifo_count)) begin
            next_rd_data = fifo_mem[rd_ptr + peek_idx];
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rd_valid <= 1'b0;
            rd_data  <= slow_ctrl_pkg::DATA_RESET;
        end else begin
            rd_valid <= req.rd;
            if (req.rd) begin
                rd_data <= next_rd_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    read_answers_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
        req.rd |=> rd_valid) else $error("read not answered");

    pulse_reads_zero_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        req.rd && req.addr == slow_ctrl_pkg::OFS_PULSE |=> rd_data == '0)
        else $error("pulse register read nonzero");

    pulse_follows_write_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        req.wr && req.addr == slow_ctrl_pkg::OFS_PULSE
        |=> pulse == $past(req.wdata[2:0]))
        else $error("pulse differs from written bits");

    pulse_one_cycle_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        pulse != '0 && !(req.wr && req.addr == slow_ctrl_pkg::OFS_PULSE)
        |=> pulse == '0) else $error("pulse longer than one cycle");

    ctrl_readback_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        (req.wr && req.addr == slow_ctrl_pkg::OFS_FRAME_LEN) ##1
        (req.rd && req.addr == slow_ctrl_pkg::OFS_FRAME_LEN)
        |=> rd_data == {24'h0, $past(req.wdata[7:0], 2)})
        else $error("frame length read back wrong");

    ctrl_hold_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
        !req.wr |=> $stable(params)) else $error("control changed");

    status_write_ignored_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        req.wr && req.addr == slow_ctrl_pkg::OFS_ERR_COUNT
        && input_err == '0 && !clear_err |=> $stable(err_count))
        else $error("status count changed by write");

    count_snapshot_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        req.rd && req.addr == slow_ctrl_pkg::OFS_ERR_COUNT
        |=> rd_data == $past(err_count)) else $error("count read torn");

    error_latch_sets_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        input_err != '0 |=> err_latch && (err_mask & $past(input_err))
        == $past(input_err)) else $error("error not latched");

    peek_keeps_fifo_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        req.rd && rd_fifo && !fifo_push && !fifo_pop && !flush
        |=> fifo_count == $past(fifo_count)) else $error("peek changed fifo");

    ram_readback_a: assert property (@(posedge clk)
        disable iff (!rst_n_sync)
        (wr_ram && !spy_we) ##1
        (req.rd && req.addr == $past(req.addr) && !spy_we)
        |=> rd_data == $past(req.wdata, 2)) else $error("ram read back wrong");

endmodule // slow_ctrl_bank

/* File: shared/slow_ctrl_pkg.sv */
package slow_ctrl_pkg;

    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int MODE_W   = 2;
    localparam int DEAD_W   = 16;
    localparam int DELAY_W  = 6;
    localparam int FRAME_W  = 8;
    localparam int OFS_W    = 8;
    localparam int INPUT_W  = 32;
    localparam int PULSE_W  = 3;

    ////////////////////////////////////////////////////////////////////////
    // Control register offsets
    localparam logic [7:0] OFS_TOB_READOUT_EN = 8'h00;
    localparam logic [7:0] OFS_INPUT_MASK     = 8'h01;
    localparam logic [7:0] OFS_RO_MODE        = 8'h02;
    localparam logic [7:0] OFS_RO_MASK        = 8'h03;
    localparam logic [7:0] OFS_DEAD_TIME      = 8'h04;
    localparam logic [7:0] OFS_INPUT_DELAY    = 8'h05;
    localparam logic [7:0] OFS_FRAME_LEN      = 8'h06;
    localparam logic [7:0] OFS_RO_OFS_INPUT   = 8'h07;
    localparam logic [7:0] OFS_RO_OFS_INTER   = 8'h08;
    localparam logic [7:0] OFS_RO_OFS_FINAL   = 8'h09;

    // Status register offsets
    localparam logic [7:0] OFS_ERR_CHECK      = 8'h10;
    localparam logic [7:0] OFS_ERR_COUNT      = 8'h11;
    localparam logic [7:0] OFS_ERR_LATCH      = 8'h12;
    localparam logic [7:0] OFS_ERR_MASK       = 8'h13;
    localparam logic [7:0] OFS_RO_STATUS      = 8'h14;

    // Pulse register and its bit positions
    localparam logic [7:0] OFS_PULSE          = 8'h20;
    localparam int PULSE_CLEAR_ERR     = 0;
    localparam int PULSE_READOUT_RESET = 1;
    localparam int PULSE_SPY_ARM       = 2;

    ////////////////////////////////////////////////////////////////////////
    // Memory windows
    localparam logic [7:0] RAM_BASE   = 8'h40;
    localparam int         RAM_AW     = 6;
    localparam int         RAM_DEPTH  = 64;
    localparam logic [7:0] FIFO_BASE  = 8'h80;
    localparam int         FIFO_AW    = 4;
    localparam int         FIFO_DEPTH = 16;
    localparam int         CNT_W      = FIFO_AW + 1;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } access_type;

    typedef struct packed {
        logic               tob_readout_en;
        logic [INPUT_W-1:0] input_mask;
        logic [MODE_W-1:0]  ro_mode;
        logic [INPUT_W-1:0] ro_mask;
        logic [DEAD_W-1:0]  dead_time;
        logic [DELAY_W-1:0] input_delay;
        logic [FRAME_W-1:0] frame_len;
        logic [OFS_W-1:0]   ofs_input;
        logic [OFS_W-1:0]   ofs_inter;
        logic [OFS_W-1:0]   ofs_final;
    } params_type;

    localparam params_type PARAMS_RESET = '0;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

endpackage

/* File: logic/readout_ram.sv */
`timescale 1ns/1ps
module readout_ram (
    input  wire logic                                   clk,
    input  wire logic                                   a_we,
    input  wire logic [slow_ctrl_pkg::RAM_AW-1:0]       a_addr,
    input  wire logic [slow_ctrl_pkg::DATA_W-1:0]       a_wdata,
    output logic      [slow_ctrl_pkg::DATA_W-1:0]       a_rdata,
    input  wire logic                                   b_we,
    input  wire logic [slow_ctrl_pkg::RAM_AW-1:0]       b_addr,
    input  wire logic [slow_ctrl_pkg::DATA_W-1:0]       b_wdata
);

    logic [slow_ctrl_pkg::DATA_W-1:0] mem [slow_ctrl_pkg::RAM_DEPTH];

    // Readout side is written after the controller, so it wins a collision
    always_ff @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
    end

    assign a_rdata = mem[a_addr];

endmodule // readout_ram

/* File: dv/ctrl_model.sv */
`timescale 1ns/1ps
module ctrl_model (
    input  wire logic                              clk,
    output slow_ctrl_pkg::access_type              req,
    input  wire logic                              rd_valid,
    input  wire logic [slow_ctrl_pkg::DATA_W-1:0]  rd_data
);
    initial begin
        req = '0;
    end
    // Requests move on the falling edge, well away from sampling
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
        // Stale data is scrambled so a late capture shows up
        req.wdata = ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [31:0] d,
                            output logic ok);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        ok = rd_valid;
        d = rd_data;
    endtask
    // Read issued right behind the write, to catch a one-cycle late update
    task automatic write_read(input logic [7:0] a, input logic [31:0] wd,
                              output logic [31:0] d, output logic ok);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~wd};
        @(negedge clk);
        req.rd = 1'b0;
        ok = rd_valid;
        d = rd_data;
    endtask
endmodule // ctrl_model

/* File: dv/slow_ctrl_register_rules_test.sv */
`timescale 1ns/1ps
module slow_ctrl_register_rules_test;
    logic                      clk;
    logic                      rst_n;
    slow_ctrl_pkg::access_type req;
    slow_ctrl_pkg::params_type params;
    logic [31:0]               rd_data, err_check, input_err, spy_data;
    logic [31:0]               fifo_data, fifo_out_data, got, d;
    logic [31:0]               w[4];
    logic [31:0]               ctl[10];
    logic [5:0]                spy_addr;
    logic [2:0]                pulse;
    logic                      rd_valid, spy_we, fifo_push, fifo_pop, ok;
    logic                      fifo_out_valid, fifo_full, fifo_empty;
    int                        n_mismatch, samples_checked, cycles;

    ctrl_model ctrl_model_i (.clk(clk), .req(req), .rd_valid(rd_valid),
        .rd_data(rd_data));
    slow_ctrl_bank slow_ctrl_bank_i (.clk(clk), .rst_n(rst_n), .req(req),
        .rd_valid(rd_valid), .rd_data(rd_data), .params(params),
        .pulse(pulse), .err_check(err_check), .input_err(input_err),
        .spy_we(spy_we), .spy_addr(spy_addr), .spy_data(spy_data),
        .fifo_push(fifo_push), .fifo_data(fifo_data), .fifo_pop(fifo_pop),
        .fifo_out_valid(fifo_out_valid), .fifo_out_data(fifo_out_data),
        .fifo_full(fifo_full), .fifo_empty(fifo_empty));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] field_mask(input int a);
        case (a)
            0: return 32'h0000_0001;
            2: return 32'h0000_0003;
            4: return 32'h0000_ffff;
            5: return 32'h0000_003f;
            1, 3: return 32'hffff_ffff;
            default: return 32'h0000_00ff;
        endcase
    endfunction
    task automatic mismatch(input string m);
        n_mismatch++;
        $display("unexpected at %0t ns: %s", $time, m);
    endtask
    task automatic check_read(input logic [7:0] a, input logic [31:0] e);
        ctrl_model_i.read_reg(a, got, ok);
        samples_checked++;
        if (ok !== 1'b1 || got !== e) begin
            mismatch($sformatf("read %h gave %h want %h", a, got, e));
        end
    endtask
    task automatic check_write_read(input logic [7:0] a,
                                    input logic [31:0] dw, e);
        ctrl_model_i.write_read(a, dw, got, ok);
        samples_checked++;
        if (ok !== 1'b1 || got !== e) begin
            mismatch($sformatf("write read %h gave %h want %h", a, got, e));
        end
    endtask
    task automatic check_port(input logic [31:0] g, e, input string m);
        samples_checked++;
        if (g !== e) begin
            mismatch($sformatf("%s is %h want %h", m, g, e));
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run is under two hundred cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatch("timeout");
            final_report();
        end
    end

    initial begin
        rst_n = 1'b0;
        input_err = '0;
        spy_we = 1'b0;
        spy_addr = '0;
        spy_data = '0;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        fifo_data = '0;
        void'($urandom(25));
        err_check = $urandom;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int a = 0; a < 10; a++) begin
            check_read(8'(a), 32'h0);
        end
        check_read(8'h20, 32'h0);
        check_read(8'h30, 32'h0);
        $display("test reset values done");
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 10; a++) begin
                d = p ? $urandom : 32'hffff_ffff;
                ctl[a] = d & field_mask(a);
                if (p) begin
                    check_write_read(8'(a), d, ctl[a]);
                end else begin
                    ctrl_model_i.write_reg(8'(a), d);
                    check_read(8'(a), ctl[a]);
                end
            end
        end
        check_port(32'(params.frame_len), ctl[6], "frame_len");
        check_port(32'(params.tob_readout_en), ctl[0], "tob_en");
        check_port(params.input_mask, ctl[1], "input_mask");
        check_port(32'(params.ro_mode), ctl[2], "ro_mode");
        check_port(params.ro_mask, ctl[3], "ro_mask");
        check_port(32'(params.dead_time), ctl[4], "dead_time");
        check_port(32'(params.input_delay), ctl[5], "delay");
        check_port(32'(params.ofs_input), ctl[7], "ofs_input");
        check_port(32'(params.ofs_inter), ctl[8], "ofs_inter");
        check_port(32'(params.ofs_final), ctl[9], "ofs_final");
        ctrl_model_i.write_reg(8'h10, ~err_check);
        check_read(8'h10, err_check);
        err_check = $urandom;
        ctrl_model_i.write_reg(8'h11, 32'hffff_ffff);
        check_read(8'h10, err_check);
        check_read(8'h11, 32'h0);
        $display("test control and status done");
        w[0] = $urandom | 32'h1;
        w[1] = 32'h8000_0000;
        for (int k = 0; k < 3; k++) begin
            input_err = k ? w[1] : w[0];
            @(negedge clk);
        end
        input_err = '0;
        check_read(8'h11, 32'h3);
        check_read(8'h12, 32'h1);
        check_read(8'h13, w[0] | w[1]);
        $display("test error status done");
        for (int b = 0; b < 4; b++) begin
            w[2] = b < 3 ? 32'h1 << b : 32'h0;
            ctrl_model_i.write_reg(8'h20, ($urandom & 32'hffff_fff8) | w[2]);
            check_port(32'(pulse), w[2], "pulse");
            @(negedge clk);
            check_port(32'(pulse), 32'h0, "pulse end");
        end
        check_read(8'h20, 32'h0);
        check_read(8'h11, 32'h0);
        for (int a = 0; a < 10; a++) begin
            check_read(8'(a), ctl[a]);
        end
        $display("test pulses done");
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            spy_addr = 6'($urandom);
            if (k[0]) begin
                spy_data = d;
                spy_we = 1'b1;
                @(negedge clk);
                spy_we = 1'b0;
                check_read(8'h40 + 8'(spy_addr), d);
            end else begin
                check_write_read(8'h40 + 8'(spy_addr), d, d);
            end
        end
        $display("test memory window done");
        for (int k = 0; k < 3; k++) begin
            w[k] = $urandom;
            fifo_data = w[k];
            fifo_push = 1'b1;
            @(negedge clk);
        end
        fifo_push = 1'b0;
        w[3] = 32'h0;
        for (int k = 0; k < 4; k++) begin
            check_read(8'h80 + 8'(k), w[k]);
        end
        fifo_pop = 1'b1;
        @(negedge clk);
        fifo_pop = 1'b0;
        check_port(32'(fifo_out_valid), 32'h1, "pop valid");
        check_port(fifo_out_data, w[0], "pop data");
        check_read(8'h80, w[1]);
        ctrl_model_i.write_reg(8'h20, 32'h2);
        repeat (2) @(negedge clk);
        check_port(32'(fifo_empty), 32'h1, "flush");
        $display("test fifo peek done");
        final_report();
    end
endmodule // slow_ctrl_register_rules_test
